// File: verif/chain_properties.sv
// pin-level assertions for the chain block
// assumes a bind onto the design top, one clock domain
module chain_chk
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // host and chain inputs
    input wire logic z_mode,
    input wire logic host_rd_n,
    input wire logic chip_select_n,
    input wire logic gp_in_four,
    input wire logic gp_in_six,
    // observed outputs
    input wire logic host_data_oe,
    input wire logic irq_request_n,
    input wire logic irq_request_oe,
    input wire logic chain_enable_out,
    input wire chain_ctrl_pkg::byte_t pending_irq,
    input wire chain_ctrl_pkg::byte_t irq_mask,
    input wire chain_ctrl_pkg::byte_t general_outputs
);
    import chain_ctrl_pkg::*;
    byte_t live; // unmasked causes
    assign live = pending_irq & irq_mask;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // held long enough to pass the input syncs
    sequence s_sel_rd;
        (!host_rd_n && !chip_select_n)[*5];
    endsequence
    sequence s_ack_rd;
        (z_mode && !gp_in_six && !host_rd_n)[*5];
    endsequence
    a_select_read_drives: assert property (s_sel_rd |-> host_data_oe)
        else $error("bus idle in select read");
    a_ack_vector_drives: assert property (s_ack_rd |-> host_data_oe)
        else $error("bus idle in ack read");
    a_bus_left_idle: assert property ((chip_select_n && (!z_mode || gp_in_six))[*5]
        |-> !host_data_oe)
        else $error("bus driven without select");
    a_chain_follows_in: assert property ((z_mode && !gp_in_four)[*4] |-> !chain_enable_out)
        else $error("chain out high with chain in low");
    a_chain_blocks_req: assert property ((z_mode && !gp_in_four)[*4] |-> !irq_request_oe)
        else $error("request with chain in low");
    a_service_holds: assert property (z_mode && irq_request_oe |-> !chain_enable_out)
        else $error("chain out high while requesting");
    a_req_has_cause: assert property (irq_request_oe |-> live != 8'h00)
        else $error("request without cause");
    a_req_follows_cause: assert property ((live != 8'h00 && (!z_mode || gp_in_four))[*4]
        |-> irq_request_oe)
        else $error("cause without request");
    a_drain_pulls_low: assert property (irq_request_oe |-> !irq_request_n)
        else $error("request pin not low");
    a_reset_state: assert property ($rose(rst_n) |-> general_outputs == 8'hff
        && chain_enable_out && pending_irq == 8'h00 && irq_mask == 8'h00)
        else $error("bad state after reset");
endmodule : chain_chk
bind reset_select_and_interrupt_chain chain_chk u_chk (.*);

// File: verif/host_model.sv
// host processor and chain peer driving the pins
// assumes tasks are called from the bench on clock edges
module host_model
(
    // clock and device answer
    input wire logic clk,
    input wire logic data_oe,
    // pins toward the device
    output logic cs_n,
    output logic rd_n,
    output logic ack_n,
    output logic chain_in
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        {cs_n, rd_n, ack_n, chain_in} = 4'hf;
    end
    // ack only just before the read that services it
    task automatic rd(input logic ack);
        @(posedge clk);
        ack_n <= ~ack;
        cs_n <= ack;
        @(posedge clk);
        rd_n <= 1'b0;
        for (int i = 0; i < 6 && !data_oe; i++)
            @(posedge clk);
        repeat (3) @(posedge clk);
    endtask : rd
    // release all strobes together
    task automatic done;
        @(posedge clk);
        {cs_n, rd_n, ack_n} <= 3'b111;
    endtask : done
    // chain input and pin six level
    task automatic pins(input logic c, input logic a);
        @(posedge clk);
        chain_in <= c;
        ack_n <= a;
    endtask : pins
endmodule : host_model

// File: verif/reset_select_and_interrupt_chain_tb.sv
// self-checking bench for the chain block
// assumes design files and host model compiled first
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module reset_select_and_interrupt_chain_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import chain_ctrl_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] stb = 5'h0; // vector, mask, outputs, config, state
    wire write_vector, write_mask, write_outputs, write_out_config, write_chan_state;
    logic z_mode, end_of_interrupt, timer_start, timer_stop, gp_in_two, gp_in_five;
    logic ext_clk_sel_a_rx, ext_clk_sel_b_rx, ext_clk_sel_b_tx, host_data_oe, irq_request_n;
    logic chip_select_n, host_rd_n, gp_in_four, gp_in_six, irq_request_oe, chain_enable_out;
    logic chan_a_rx_ext_clock, chan_b_rx_ext_clock, chan_b_tx_ext_clock, timer_ext_clock;
    logic timer_running, chan_a_serial_out, chan_b_serial_out, channels_active;
    byte_t host_wdata, read_data, irq_sources, irq_clear, v, got, host_data_out;
    byte_t general_outputs, output_pin_config, pending_irq, irq_mask, channel_state;
    int checks = 0;
    int miscompares = 0;
    int pend_m = 0; // pending flags model, set wins
    int vec_m = 32'h0f; // expected vector register
    wire [3:0] ext = {chan_b_rx_ext_clock, chan_b_tx_ext_clock, chan_a_rx_ext_clock,
        timer_ext_clock};
    assign {write_vector, write_mask, write_outputs, write_out_config, write_chan_state} = stb;
    always #25 clk = ~clk;
    reset_select_and_interrupt_chain u_dut
    (
        .clk, .rst_n, .z_mode, .host_rd_n, .chip_select_n, .host_wdata, .write_vector,
        .write_mask, .write_outputs, .write_out_config, .write_chan_state, .end_of_interrupt,
        .read_data, .irq_sources, .irq_clear, .timer_start, .timer_stop, .gp_in_two,
        .gp_in_four, .gp_in_five, .gp_in_six, .ext_clk_sel_a_rx, .ext_clk_sel_b_rx,
        .ext_clk_sel_b_tx, .host_data_out, .host_data_oe, .irq_request_n, .irq_request_oe,
        .chain_enable_out, .chan_a_rx_ext_clock, .chan_b_rx_ext_clock, .chan_b_tx_ext_clock,
        .timer_ext_clock, .timer_running, .general_outputs, .output_pin_config,
        .chan_a_serial_out, .chan_b_serial_out, .channels_active, .pending_irq, .irq_mask,
        .channel_state
    );
    host_model u_host
    (
        .clk, .data_oe(host_data_oe), .cs_n(chip_select_n), .rd_n(host_rd_n),
        .ack_n(gp_in_six), .chain_in(gp_in_four)
    );
    task automatic conclude;
        if (miscompares == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : conclude
    // state held while reset is low
    task automatic rcheck;
        #1;
        `CHK("outs", 8'hff, general_outputs)
        `CHK("ser", 3'b110, {chan_a_serial_out, chan_b_serial_out, channels_active})
        `CHK("regs", 32'h0, {pending_irq, irq_mask, output_pin_config, channel_state})
        `CHK("timer", 1'b0, timer_running)
    endtask : rcheck
    // one strobed register write
    task automatic wr(input int k, input byte_t d);
        @(posedge clk);
        host_wdata <= d;
        stb <= 5'h1 << k;
        @(posedge clk);
        stb <= 5'h0;
    endtask : wr
    // one bus read, drive expected or refused
    task automatic vread(input logic ack, input logic eoe, input int ev);
        u_host.rd(ack);
        #1;
        `CHK("drive", eoe, host_data_oe)
        if (eoe)
            `CHK("data", ev[7:0], host_data_out)
        u_host.done();
        repeat (4) @(posedge clk);
        #1;
        `CHK("float", 1'b0, host_data_oe)
    endtask : vread
    // one-cycle pulse on the sources or clears
    task automatic hit(input logic clr, input byte_t b);
        @(posedge clk);
        if (clr)
        begin
            irq_clear <= b;
            pend_m = pend_m & ~int'(b);
        end
        else
        begin
            irq_sources <= b;
            pend_m = pend_m | int'(b);
        end
        @(posedge clk);
        {irq_sources, irq_clear} <= 16'h0;
    endtask : hit
    // main sequence
    initial
    begin
        {z_mode, end_of_interrupt, timer_start, timer_stop, gp_in_two, gp_in_five} = '0;
        {ext_clk_sel_a_rx, ext_clk_sel_b_rx, ext_clk_sel_b_tx} = '0;
        {host_wdata, read_data, irq_sources, irq_clear} = '0;
        void'($urandom(32'h6237));
        repeat (4) @(posedge clk);
        rcheck();
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int k = 0; k < 4; k++)
        begin
            v = byte_t'($urandom);
            wr(k, v);
            @(posedge clk);
            #1;
            got = k[1] ? (k[0] ? irq_mask : ~general_outputs)
                : (k[0] ? output_pin_config : channel_state);
            `CHK("reg", v, got)
        end
        @(posedge clk);
        timer_start <= 1'b1;
        read_data <= byte_t'($urandom);
        @(posedge clk);
        timer_start <= 1'b0;
        vread(1'b0, 1'b1, read_data);
        vread(1'b1, 1'b0, 0);
        @(posedge clk);
        {ext_clk_sel_a_rx, ext_clk_sel_b_rx, ext_clk_sel_b_tx} <= 3'b111;
        repeat (6)
        begin
            v = byte_t'($urandom);
            u_host.pins(v[1], v[3]);
            {gp_in_five, gp_in_two} <= {v[2], v[0]};
            repeat (4) @(posedge clk);
            #1;
            `CHK("ext", v[3:0], ext)
        end
        u_host.pins(1'b1, 1'b1);
        z_mode <= 1'b1;
        // the host acknowledges only a request that stands, so raise one first
        wr(3, 8'hff);
        u_host.pins(1'b0, 1'b1);
        v = 8'h01 << ($urandom % 8);
        hit(1'b0, v);
        repeat (6) @(posedge clk);
        #1;
        `CHK("blocked", 2'b00, {irq_request_oe, chain_enable_out})
        u_host.pins(1'b1, 1'b1);
        repeat (6) @(posedge clk);
        #1;
        `CHK("req", 2'b10, {irq_request_oe, chain_enable_out})
        `CHK("pend", pend_m[7:0], pending_irq)
        vread(1'b1, 1'b1, vec_m);
        vec_m = $urandom % 256;
        wr(4, vec_m[7:0]);
        vread(1'b1, 1'b1, vec_m);
        vread(1'b1, 1'b1, vec_m);
        hit(1'b1, v);
        repeat (6) @(posedge clk);
        #1;
        `CHK("served", 2'b00, {irq_request_oe, chain_enable_out})
        `CHK("clear", pend_m[7:0], pending_irq)
        @(posedge clk);
        end_of_interrupt <= 1'b1;
        @(posedge clk);
        end_of_interrupt <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        `CHK("freed", 1'b1, chain_enable_out)
        `CHK("run", 1'b1, timer_running)
        @(posedge clk);
        rst_n <= 1'b0;
        pend_m = 0;
        rcheck();
        @(posedge clk);
        rst_n <= 1'b1;
        // pins need the syncs, and the acknowledge needs a standing request
        repeat (3) @(posedge clk);
        wr(3, 8'hff);
        hit(1'b0, 8'h01);
        repeat (6) @(posedge clk);
        vread(1'b1, 1'b1, 32'h0f);
        conclude();
    end
    // cut a hang short
    initial
    begin
        #100us;
        miscompares++;
        conclude();
    end
endmodule : reset_select_and_interrupt_chain_tb

// File: verilog/chain_ctrl_params.svh
// constants for the reset, select and interrupt chain block
// assumes inclusion by the package and the design file only
`ifndef CHAIN_CTRL_PARAMS_SVH
`define CHAIN_CTRL_PARAMS_SVH
`define VECTOR_RESET 8'h0f
`define REG_CLEAR 8'h00
`define OUTPUTS_IDLE 8'hff
`define MARK_LEVEL 1'b1
`define IRQ_COUNT 8
`endif

// File: verilog/chain_ctrl_pkg.sv
// types for the reset, select and interrupt chain block
// assumes the params header sits beside it
`include "chain_ctrl_params.svh"
package chain_ctrl_pkg;
    typedef logic [7:0] byte_t;
    // chain service state
    typedef enum logic [1:0]
    {
        chain_idle = 2'b00,
        chain_request = 2'b01,
        chain_service = 2'b10
    } chain_state_e;
endpackage : chain_ctrl_pkg

// File: verilog/reset_select_and_interrupt_chain.sv
// reset, chip select gating, shared pin roles and interrupt chain
// assumes a 20 MHz clk, async active-low rst_n from the master reset pin
`include "chain_ctrl_params.svh"
module reset_select_and_interrupt_chain
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // mode and register writes from the host decode
    input wire logic z_mode,
    input wire logic host_rd_n,
    input wire logic chip_select_n,
    input wire chain_ctrl_pkg::byte_t host_wdata,
    input wire logic write_vector,
    input wire logic write_mask,
    input wire logic write_outputs,
    input wire logic write_out_config,
    input wire logic write_chan_state,
    input wire logic end_of_interrupt,
    input wire chain_ctrl_pkg::byte_t read_data,
    // interrupt sources and timer run request
    input wire chain_ctrl_pkg::byte_t irq_sources,
    input wire chain_ctrl_pkg::byte_t irq_clear,
    input wire logic timer_start,
    input wire logic timer_stop,
    // shared input pins and the clock selects for them
    input wire logic gp_in_two,
    input wire logic gp_in_four,
    input wire logic gp_in_five,
    input wire logic gp_in_six,
    input wire logic ext_clk_sel_a_rx,
    input wire logic ext_clk_sel_b_rx,
    input wire logic ext_clk_sel_b_tx,
    // data bus pin pieces
    output chain_ctrl_pkg::byte_t host_data_out,
    output logic host_data_oe,
    // interrupt pins
    output logic irq_request_n,
    output logic irq_request_oe,
    output logic chain_enable_out,
    // pin roles and state
    output logic chan_a_rx_ext_clock,
    output logic chan_b_rx_ext_clock,
    output logic chan_b_tx_ext_clock,
    output logic timer_ext_clock,
    output logic timer_running,
    output chain_ctrl_pkg::byte_t general_outputs,
    output chain_ctrl_pkg::byte_t output_pin_config,
    output logic chan_a_serial_out,
    output logic chan_b_serial_out,
    output logic channels_active,
    output chain_ctrl_pkg::byte_t pending_irq,
    output chain_ctrl_pkg::byte_t irq_mask,
    output chain_ctrl_pkg::byte_t channel_state
);
    import chain_ctrl_pkg::*;

    // z-mode hands a shared pin to the chain; outside it the role rests inactive high
    function automatic logic z_role
    (
        input logic mode,
        input logic pin
    );
        z_role = mode ? pin : 1'b1;
    endfunction : z_role

    // clock role of a shared pin: i-mode only, and only when its select is set
    // a pin used as a clock is passed as a level, so its edges lag by two syncs and the output register
    function automatic logic ext_role
    (
        input logic mode,
        input logic sel,
        input logic pin
    );
        ext_role = !mode && sel && pin;
    endfunction : ext_role

    // two-stage synchronisers for all pin inputs
    logic [5:0] sync_a;
    logic [5:0] sync_b;
    wire [5:0] pins_raw = {gp_in_two, gp_in_four, gp_in_five, gp_in_six, host_rd_n,
        chip_select_n};

    // registers of the block
    byte_t vector_reg;
    byte_t channel_state_reg;
    byte_t pending_irq_reg;
    byte_t irq_mask_reg;
    byte_t output_pin_value_reg;
    byte_t output_pin_config_reg;
    chain_state_e chain_state;
    chain_state_e next_chain_state;

    // synchronised pin views
    wire in_two = sync_b[5];
    wire in_four = sync_b[4];
    wire in_five = sync_b[3];
    wire in_six = sync_b[2];
    wire rd_n_s = sync_b[1];
    wire cs_n_s = sync_b[0];
    // z-mode roles: pin six acknowledge, pin four chain in
    // z_mode is a strap from the host decode on this clock, so it needs no sync
    wire vector_ack_n = z_role(z_mode, in_six);
    wire chain_enable_in = z_role(z_mode, in_four);
    // i-mode clock roles of the shared pins
    wire next_a_rx_clock = ext_role(z_mode, ext_clk_sel_a_rx, in_four);
    wire next_b_rx_clock = ext_role(z_mode, ext_clk_sel_b_rx, in_six);
    wire next_b_tx_clock = ext_role(z_mode, ext_clk_sel_b_tx, in_five);

    // unmasked pending conditions; chain in gates them in z-mode
    // a source and a clear in one cycle leave the bit set, so no event is lost
    wire [7:0] next_pending = (pending_irq_reg & ~irq_clear) | irq_sources;
    wire any_unmasked = |(pending_irq_reg & irq_mask_reg);
    wire req_allowed = any_unmasked && chain_enable_in;

    // bus drive: select low read, or z-mode acknowledge read
    // strobes cross the same syncs as the pins, so drive follows by three edges
    wire ack_cycle = z_mode && !vector_ack_n && !rd_n_s;
    wire sel_read = !cs_n_s && !rd_n_s;
    wire next_oe = sel_read || ack_cycle;
    wire [7:0] next_data = ack_cycle ? vector_reg : read_data;

    // chain out: low while chain in is low, or while this block requests or is served
    wire next_chain_out = chain_enable_in && next_chain_state == chain_idle;

    // pin sync; first stage read only by the second
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // pins rest high, so a high reset avoids a false low after release
            sync_a <= 6'h3f;
            sync_b <= 6'h3f;
        end
        else
        begin
            sync_a <= pins_raw;
            sync_b <= sync_a;
        end
    end

    // chain state: idle, own request, serviced until end command
    always_comb
    begin
        next_chain_state = chain_state;
        unique case (chain_state)
            chain_idle:
            begin
                // no request is started while chain in is low
                if (req_allowed)
                begin
                    next_chain_state = chain_request;
                end
            end
            chain_request:
            begin
                // acknowledge moves into service; with no unmasked cause left the request returns to idle
                if (ack_cycle)
                begin
                    next_chain_state = chain_service;
                end
                else if (!any_unmasked)
                begin
                    next_chain_state = chain_idle;
                end
            end
            chain_service:
            begin
                // a cause still pending after the end command asks again at once,
                // so chain out never shows a one-cycle high between services
                if (end_of_interrupt)
                begin
                    next_chain_state = req_allowed ? chain_request : chain_idle;
                end
            end
            default:
            begin
                // the unused state code falls back to idle
                next_chain_state = chain_idle;
            end
        endcase
    end

    // host-written registers and pending flags; set wins over clear
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            vector_reg <= `VECTOR_RESET;
            channel_state_reg <= `REG_CLEAR;
            pending_irq_reg <= `REG_CLEAR;
            irq_mask_reg <= `REG_CLEAR;
            output_pin_value_reg <= `REG_CLEAR;
            output_pin_config_reg <= `REG_CLEAR;
        end
        else
        begin
            pending_irq_reg <= next_pending;
            // writes come from the host decode on this clock, so no sync is needed
            if (write_vector)
                vector_reg <= host_wdata;
            if (write_mask)
                irq_mask_reg <= host_wdata;
            if (write_outputs)
                output_pin_value_reg <= host_wdata;
            if (write_out_config)
                output_pin_config_reg <= host_wdata;
            if (write_chan_state)
                channel_state_reg <= host_wdata;
        end
    end

    // chain, request and bus outputs, all registered
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            chain_state <= chain_idle;
            irq_request_n <= 1'b0; // open drain data low, enable off
            irq_request_oe <= 1'b0;
            chain_enable_out <= 1'b1;
            host_data_out <= `REG_CLEAR;
            host_data_oe <= 1'b0;
        end
        else
        begin
            chain_state <= next_chain_state;
            // pin data stays low; only the enable moves, as on an open drain
            irq_request_n <= 1'b0;
            irq_request_oe <= req_allowed;
            // registered so the pin cannot glitch while the state decode settles
            chain_enable_out <= next_chain_out;
            host_data_out <= next_data;
            host_data_oe <= next_oe;
        end
    end

    // timer run flag, halted by reset
    // counting lives in the timer block; only the run state is kept here
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            timer_running <= 1'b0;
        else if (timer_stop)
            timer_running <= 1'b0;
        else if (timer_start)
            timer_running <= 1'b1;
    end

    // pin roles and general outputs; outputs driven as inverted value
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // every output pin high: value register clear, pins inverted
            general_outputs <= `OUTPUTS_IDLE;
            chan_a_serial_out <= `MARK_LEVEL;
            chan_b_serial_out <= `MARK_LEVEL;
            channels_active <= 1'b0;
            chan_a_rx_ext_clock <= 1'b0;
            chan_b_rx_ext_clock <= 1'b0;
            chan_b_tx_ext_clock <= 1'b0;
            timer_ext_clock <= 1'b0;
            output_pin_config <= `REG_CLEAR;
            pending_irq <= `REG_CLEAR;
            irq_mask <= `REG_CLEAR;
            channel_state <= `REG_CLEAR;
        end
        else
        begin
            // pins carry the complement of the value register
            general_outputs <= ~output_pin_value_reg;
            // serial datapaths live elsewhere; lines held marking here
            chan_a_serial_out <= `MARK_LEVEL;
            chan_b_serial_out <= `MARK_LEVEL;
            channels_active <= |channel_state_reg;
            // channel external clocks only in i-mode, gated by selects; timer clock follows pin two in both modes
            chan_a_rx_ext_clock <= next_a_rx_clock;
            chan_b_rx_ext_clock <= next_b_rx_clock;
            chan_b_tx_ext_clock <= next_b_tx_clock;
            timer_ext_clock <= in_two;
            output_pin_config <= output_pin_config_reg;
            pending_irq <= pending_irq_reg;
            irq_mask <= irq_mask_reg;
            channel_state <= channel_state_reg;
        end
    end
endmodule : reset_select_and_interrupt_chain
